/* File: rcb_bank.sv */
// Bank of 256 reversible counters with range reset, Wishbone slave
// Operation
// - Each rising up input adds one to the present count.
// - Each rising down input subtracts one from the present count.
// - Each count evaluation leaves the present count between zero and the preset limit, except a decimal up step with a limit that is not valid BCD.
// - Up from limit wraps to zero, sets done; zero to one clears it.
// - Down from zero wraps to limit, sets done; next down clears it.
// - Both inputs rising together leave the count unchanged.
// - Reset input holds count at zero and ignores count inputs.
// - Slot index 0 to 255 gives 256 counter slots.
// - Decimal variant flags fault when limit is not valid BCD.
// - Count state is per slot, shared by both variants.
// - Limit is sampled fresh at every evaluation.
// - Range reset clears done flags and loads maximum counts.
// - After range reset, count reloads from limit at next evaluation.
// - Range reset faults when ends lie in different areas.
// - First index above last clears only that slot's done flag.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module rcb_bank import rcb_pkg::*; #(
	parameter int SLOTS = RCB_SLOTS
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	output logic             operation_fault_flag,
	output logic             irq
);
	initial begin
		if (SLOTS < 1 || SLOTS > RCB_SLOTS) $error("rcb_bank: SLOTS out of range");
	end

	// ****************************************
	// Storage and registers
	// ****************************************
	rcb_slot_t         slot_q [SLOTS];
	rcb_req_t          req_q;
	logic              go_q;
	logic              fault_q;
	logic [RCB_IRQ_W-1:0] irq_st_q;
	logic [RCB_IRQ_W-1:0] irq_mask_q;
	logic              ack_q;
	logic [31:0]       rdat_q;

	logic              bus_req;
	logic              wr;
	logic              rd;
	logic              mapped;
	logic              st_rd_clr;
	logic [31:0]       rdat_d;

	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_err_o;
	assign mapped  = (wb_adr_i <= RCB_A_IRQ_MASK) && (wb_adr_i[1:0] == 2'b00);
	assign wr      = bus_req & wb_we_i & mapped;
	assign rd      = bus_req & ~wb_we_i & mapped;

	// ****************************************
	// Evaluation of the addressed slot
	// ****************************************
	rcb_slot_t   cur;
	logic [15:0] nxt_count;
	logic        nxt_done;
	logic        wrapped;
	logic        bcd_fault;
	logic        up_edge;
	logic        down_edge;
	logic        is_count;
	logic        is_binary;
	logic        area_fault;
	logic        range_single;

	assign cur       = slot_q[req_q.slot];
	assign is_count  = (req_q.op == RCB_OP_COUNT_BCD) || (req_q.op == RCB_OP_COUNT_BIN);
	assign is_binary = (req_q.op == RCB_OP_COUNT_BIN) || (req_q.op == RCB_OP_RANGE_BIN);
	assign up_edge   = req_q.up_count_input & ~cur.up_prev;
	assign down_edge = req_q.down_count_input & ~cur.down_prev;
	assign area_fault   = req_q.first_is_timer != req_q.last_is_timer;
	assign range_single = req_q.range_first_index > req_q.range_last_index;

	rcb_step u_step (
		.binary       (is_binary),
		.up_edge      (up_edge),
		.down_edge    (down_edge),
		.reset_input  (req_q.reset_input),
		.preset_limit (req_q.preset_limit),
		.cur_count    (cur.present_count),
		.cur_done     (cur.done),
		.nxt_count    (nxt_count),
		.nxt_done     (nxt_done),
		.wrapped      (wrapped),
		.bcd_fault    (bcd_fault)
	);

	// Timer-area slots are not held here, so only counter ranges touch storage
	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : gen_slot
			logic in_range;
			assign in_range = range_single ? (g == req_q.range_first_index)
				: (g >= req_q.range_first_index && g <= req_q.range_last_index);
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					slot_q[g] <= '0;
				end else if (clk_en && go_q) begin
					if (is_count && g == req_q.slot) begin
						slot_q[g].present_count <= nxt_count;
						slot_q[g].done          <= nxt_done;
						slot_q[g].up_prev       <= req_q.up_count_input;
						slot_q[g].down_prev     <= req_q.down_count_input;
					end else if (!is_count && !area_fault && !req_q.first_is_timer
						&& in_range) begin
						slot_q[g].done <= 1'b0;
						if (!range_single) begin
							slot_q[g].present_count <= is_binary ? RCB_BIN_MAX
								: RCB_BCD_MAX;
						end
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Command register and fault flag
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			req_q <= '0;
			go_q  <= 1'b0;
		end else if (clk_en) begin
			go_q <= 1'b0;
			if (wr && wb_sel_i[0]) begin
				case (wb_adr_i)
					RCB_A_CMD: begin
						req_q.op <= wb_dat_i[RCB_B_RANGE]
							? (wb_dat_i[RCB_B_BINARY] ? RCB_OP_RANGE_BIN : RCB_OP_RANGE_BCD)
							: (wb_dat_i[RCB_B_BINARY] ? RCB_OP_COUNT_BIN : RCB_OP_COUNT_BCD);
						req_q.up_count_input   <= wb_dat_i[RCB_B_UP];
						req_q.down_count_input <= wb_dat_i[RCB_B_DOWN];
						req_q.reset_input      <= wb_dat_i[RCB_B_RESET];
						req_q.first_is_timer   <= wb_dat_i[RCB_B_FIRST_TMR];
						req_q.last_is_timer    <= wb_dat_i[RCB_B_LAST_TMR];
						go_q                   <= wb_dat_i[RCB_B_GO];
					end
					RCB_A_SLOT:  req_q.slot <= wb_dat_i[7:0];
					RCB_A_RANGE: begin
						req_q.range_first_index <= wb_dat_i[7:0];
						req_q.range_last_index  <= wb_dat_i[15:8];
					end
					default: ;
				endcase
			end
			if (wr && wb_adr_i == RCB_A_LIMIT) begin
				if (wb_sel_i[0]) req_q.preset_limit[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) req_q.preset_limit[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			fault_q <= 1'b0;
		end else if (clk_en && go_q) begin
			fault_q <= is_count ? bcd_fault : area_fault;
		end
	end
	assign operation_fault_flag = fault_q;

	// ****************************************
	// Interrupt status: events set, read clears
	// ****************************************
	logic [RCB_IRQ_W-1:0] ev;
	always_comb begin
		ev = '0;
		ev[RCB_E_DONE]  = go_q & is_count & nxt_done & ~cur.done;
		ev[RCB_E_WRAP]  = go_q & is_count & wrapped;
		ev[RCB_E_FAULT] = go_q & (is_count ? bcd_fault : area_fault);
	end
	assign st_rd_clr = rd && wb_adr_i == RCB_A_IRQ_ST;

	// Set wins over the clearing read so no event is lost
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irq_st_q   <= '0;
			irq_mask_q <= '0;
		end else if (clk_en) begin
			irq_st_q <= (st_rd_clr ? '0 : irq_st_q) | ev;
			if (wr && wb_adr_i == RCB_A_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[RCB_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_st_q & irq_mask_q);

	// ****************************************
	// Wishbone answer: one wait state
	// ****************************************
	always_comb begin
		rdat_d = 32'h0000_0000;
		case (wb_adr_i)
			RCB_A_SLOT:     rdat_d = {24'h00_0000, req_q.slot};
			RCB_A_LIMIT:    rdat_d = {16'h0000, req_q.preset_limit};
			RCB_A_RANGE:    rdat_d = {16'h0000, req_q.range_last_index,
				req_q.range_first_index};
			RCB_A_COUNT:    rdat_d = {16'h0000, slot_q[req_q.slot].present_count};
			RCB_A_STATUS:   rdat_d = {29'h0000_0000, go_q, fault_q, slot_q[req_q.slot].done};
			RCB_A_IRQ_ST:   rdat_d = {29'h0000_0000, irq_st_q};
			RCB_A_IRQ_MASK: rdat_d = {29'h0000_0000, irq_mask_q};
			default:        rdat_d = 32'h0000_0000;
		endcase
	end

	logic err_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ack_q  <= 1'b0;
			err_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q  <= bus_req & mapped;
			err_q  <= bus_req & ~mapped;
			rdat_q <= rd ? rdat_d : rdat_q;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	chk_count_in_range: assert property (
		(clk_en && go_q && is_count && !req_q.reset_input) |=>
			slot_q[$past(req_q.slot)].present_count <= $past(req_q.preset_limit))
		else $error("count left the range");
	chk_reset_zero: assert property (
		(clk_en && go_q && is_count && req_q.reset_input) |=>
			slot_q[$past(req_q.slot)].present_count == RCB_ZERO)
		else $error("reset did not zero count");
	chk_up_wrap: assert property (
		(clk_en && go_q && is_count && up_edge && !down_edge && !req_q.reset_input
			&& cur.present_count == req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].done && slot_q[$past(req_q.slot)].present_count == 0)
		else $error("up wrap wrong");
	chk_down_wrap: assert property (
		(clk_en && go_q && is_count && down_edge && !up_edge && !req_q.reset_input
			&& cur.present_count == RCB_ZERO) |=>
			slot_q[$past(req_q.slot)].done
			&& slot_q[$past(req_q.slot)].present_count == $past(req_q.preset_limit))
		else $error("down wrap wrong");
	chk_both_edges: assert property (
		(clk_en && go_q && is_count && up_edge && down_edge && !req_q.reset_input
			&& cur.present_count <= req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].present_count == $past(cur.present_count))
		else $error("both edges changed count");
	chk_up_step: assert property (
		(clk_en && go_q && is_count && is_binary && up_edge && !down_edge
			&& !req_q.reset_input && cur.present_count < req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].present_count == $past(cur.present_count) + 16'h0001)
		else $error("up step wrong");
	chk_fault_flag: assert property (
		(clk_en && go_q) |=> operation_fault_flag == $past(is_count ? bcd_fault : area_fault))
		else $error("fault flag wrong");
	chk_range_max: assert property (
		(clk_en && go_q && !is_count && !area_fault && !req_q.first_is_timer
			&& !range_single) |=>
			slot_q[$past(req_q.range_first_index)].present_count
			== ($past(is_binary) ? RCB_BIN_MAX : RCB_BCD_MAX))
		else $error("range reset did not load maximum");
	chk_irq_level: assert property (
		(clk_en && st_rd_clr && ev == '0) |=> !irq)
		else $error("interrupt not cleared by read");
	chk_down_step: assert property (
		(clk_en && go_q && is_count && is_binary && down_edge && !up_edge
			&& !req_q.reset_input && cur.present_count != RCB_ZERO
			&& cur.present_count <= req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].present_count == $past(cur.present_count) - 16'h0001)
		else $error("down step wrong");
	chk_up_clear: assert property (
		(clk_en && go_q && is_count && up_edge && !down_edge && !req_q.reset_input
			&& cur.present_count < req_q.preset_limit) |=>
			!slot_q[$past(req_q.slot)].done)
		else $error("up step left done set");
	chk_down_clear: assert property (
		(clk_en && go_q && is_count && down_edge && !up_edge && !req_q.reset_input
			&& cur.present_count != RCB_ZERO && cur.present_count <= req_q.preset_limit) |=>
			!slot_q[$past(req_q.slot)].done)
		else $error("down step left done set");
	chk_no_edge_hold: assert property (
		(clk_en && go_q && is_count && !up_edge && !down_edge && !req_q.reset_input
			&& cur.present_count <= req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].present_count == $past(cur.present_count))
		else $error("count moved without an edge");
	chk_reload: assert property (
		(clk_en && go_q && is_count && !up_edge && !down_edge && !req_q.reset_input
			&& cur.present_count > req_q.preset_limit) |=>
			slot_q[$past(req_q.slot)].present_count == $past(req_q.preset_limit))
		else $error("count above limit not reloaded");
	chk_range_last: assert property (
		(clk_en && go_q && !is_count && !area_fault && !req_q.first_is_timer
			&& !range_single) |=>
			!slot_q[$past(req_q.range_last_index)].done
			&& slot_q[$past(req_q.range_last_index)].present_count
			== ($past(is_binary) ? RCB_BIN_MAX : RCB_BCD_MAX))
		else $error("range reset missed the last slot");
	chk_single_keep: assert property (
		(clk_en && go_q && !is_count && !area_fault && !req_q.first_is_timer
			&& range_single) |=>
			!slot_q[$past(req_q.range_first_index)].done
			&& slot_q[$past(req_q.range_first_index)].present_count
			== $past(slot_q[req_q.range_first_index].present_count))
		else $error("single-slot reset changed the count");
	chk_bin_no_fault: assert property (
		(clk_en && go_q && is_count && is_binary) |=> !operation_fault_flag)
		else $error("binary count raised a fault");
	chk_area_fault: assert property (
		(clk_en && go_q && !is_count) |=>
			operation_fault_flag == $past(req_q.first_is_timer ^ req_q.last_is_timer))
		else $error("range fault flag wrong");
	// Bus answers last one cycle and never both kinds at once
	chk_ack_pulse: assert property (
		(clk_en && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held too long");
	chk_err_unmapped: assert property (
		(clk_en && bus_req && !mapped) |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	// A low enable must freeze everything, the bus answer included
	chk_freeze: assert property (
		!clk_en |=> $stable(req_q) && $stable(fault_q) && $stable(irq_st_q)
			&& $stable(wb_ack_o) && $stable(cur))
		else $error("state moved while enable low");

	cov_up_wrap:   cover property (go_q && is_count && wrapped && up_edge);
	cov_down_wrap: cover property (go_q && is_count && wrapped && down_edge);
	cov_range:     cover property (go_q && !is_count && !area_fault);
	cov_single:    cover property (go_q && !is_count && range_single);
	cov_freeze:    cover property (!clk_en && wb_cyc_i && wb_stb_i);

endmodule : rcb_bank

/* File: rcb_bank_bench.sv */
// Self-checking bench for the reversible counter bank
`timescale 1ns/1ps
module rcb_bank_bench import rcb_pkg::*; ;
	localparam logic [31:0] RG = 32'h02;
	localparam logic [31:0] BN = 32'h04;
	localparam logic [31:0] UP = 32'h08;
	localparam logic [31:0] DN = 32'h10;
	localparam logic [31:0] RS = 32'h20;
	localparam logic [31:0] FT = 32'h40;

	logic        sys_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        clk_en  = 1'b1;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [3:0]  wb_sel_i;
	logic        wb_we_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        wb_err_o;
	logic        operation_fault_flag;
	logic        irq;
	logic [31:0] rd;
	logic        be;
	logic [15:0] i;
	int          err_count  = 0;
	int          n_compared = 0;

	always #4 sys_clk = ~sys_clk;

	rcb_bank #(.SLOTS(256)) DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .operation_fault_flag(operation_fault_flag), .irq(irq));

	rcb_host host (.sys_clk(sys_clk), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
		logic to;
		host.xfer(we, a, d, rd, be, to);
		if (to) begin
			err_count++;
			print_verdict();
		end
	endtask : acc

	// One evaluation with the given inputs; edges exist only against the previous one
	task automatic ev(input logic [31:0] c);
		acc(1'b1, RCB_A_CMD, c | 32'h01);
	endtask : ev

	task automatic pulse(input logic [31:0] c);
		ev(c);
		ev(c & ~(UP | DN));
	endtask : pulse

	task automatic cnt(input logic [15:0] e, input logic d);
		acc(1'b0, RCB_A_COUNT, 32'h0);
		chk("count", rd, {16'h0000, e});
		acc(1'b0, RCB_A_STATUS, 32'h0);
		chk("done", rd & 32'h1, {31'h0, d});
	endtask : cnt

	task automatic flag(input string nm, input logic seen, input logic exp);
		@(negedge sys_clk);
		chk(nm, {31'h0, seen}, {31'h0, exp});
	endtask : flag

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		flag("irq", irq, 1'b0);
		acc(1'b0, RCB_A_IRQ_MASK, 32'h0);
		chk("mask", rd, 32'h0);
		acc(1'b1, RCB_A_SLOT, 32'h05);
		acc(1'b1, RCB_A_LIMIT, 32'h0003);
		ev(RS);
		ev(32'h0);
		for (i = 16'h1; i <= 16'h3; i++) begin
			pulse(UP);
			cnt(i, 1'b0);
		end
		pulse(UP);
		cnt(16'h0000, 1'b1);
		pulse(UP);
		cnt(16'h0001, 1'b0);
		pulse(DN);
		cnt(16'h0000, 1'b0);
		pulse(DN);
		cnt(16'h0003, 1'b1);
		pulse(DN);
		cnt(16'h0002, 1'b0);
		pulse(UP | DN);
		cnt(16'h0002, 1'b0);
		ev(RS | UP);
		cnt(16'h0000, 1'b0);
		ev(32'h0);
		pulse(UP | BN);
		cnt(16'h0001, 1'b0);
		acc(1'b1, RCB_A_LIMIT, 32'h0001);
		pulse(UP);
		cnt(16'h0000, 1'b1);
		acc(1'b1, RCB_A_RANGE, 32'h0605);
		ev(RG);
		cnt(16'h9999, 1'b0);
		acc(1'b1, RCB_A_SLOT, 32'h06);
		cnt(16'h9999, 1'b0);
		acc(1'b1, RCB_A_SLOT, 32'h07);
		cnt(16'h0000, 1'b0);
		acc(1'b1, RCB_A_SLOT, 32'h05);
		ev(RG | BN);
		flag("fault", operation_fault_flag, 1'b0);
		cnt(16'hFFFF, 1'b0);
		ev(32'h0);
		cnt(16'h0001, 1'b0);
		ev(RG | FT);
		flag("fault", operation_fault_flag, 1'b1);
		cnt(16'h0001, 1'b0);
		pulse(UP);
		acc(1'b1, RCB_A_RANGE, 32'h0405);
		ev(RG);
		cnt(16'h0000, 1'b0);
		acc(1'b1, RCB_A_SLOT, 32'hFF);
		pulse(UP);
		cnt(16'h0001, 1'b0);
		ev(UP);
		ev(UP);
		cnt(16'h0000, 1'b1);
		ev(32'h0);
		acc(1'b1, RCB_A_SLOT, 32'h05);
		cnt(16'h0000, 1'b0);
		acc(1'b0, RCB_A_IRQ_ST, 32'h0);
		pulse(UP);
		pulse(UP);
		flag("irq", irq, 1'b0);
		acc(1'b1, RCB_A_IRQ_MASK, 32'h2);
		flag("irq", irq, 1'b1);
		acc(1'b0, RCB_A_IRQ_ST, 32'h0);
		chk("irq_st", rd, 32'h0000_0003);
		flag("irq", irq, 1'b0);
		acc(1'b0, 8'h20, 32'h0);
		chk("err", {31'h0, be}, 32'h1);
		acc(1'b1, RCB_A_LIMIT, 32'h00A0);
		ev(32'h0);
		flag("fault", operation_fault_flag, 1'b1);
		ev(BN);
		flag("fault", operation_fault_flag, 1'b0);
		pulse(UP | BN);
		pulse(UP | BN);
		pulse(DN | BN);
		cnt(16'h0001, 1'b0);
		// A frozen enable must hold back the answer to a pending read
		@(posedge sys_clk);
		clk_en <= 1'b0;
		fork
			acc(1'b0, RCB_A_COUNT, 32'h0);
			begin
				repeat (4) @(posedge sys_clk);
				chk("frozen ack", {31'h0, wb_ack_o}, 32'h0);
				clk_en <= 1'b1;
			end
		join
		chk("frozen count", rd, 32'h0000_0001);
		// Reset in mid-run clears registers and slot storage alike
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		flag("irq", irq, 1'b0);
		acc(1'b0, RCB_A_IRQ_MASK, 32'h0);
		chk("mask", rd, 32'h0);
		acc(1'b1, RCB_A_SLOT, 32'h05);
		cnt(16'h0000, 1'b0);
		print_verdict();
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		err_count++;
		print_verdict();
	end
endmodule : rcb_bank_bench

/* File: rcb_host.sv */
// Wishbone classic host model that drives the counter bank registers
`timescale 1ns/1ps
module rcb_host (
	input  wire logic        sys_clk,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        wb_err_o,
	output logic      [7:0]  wb_adr_i,
	output logic      [31:0] wb_dat_i,
	output logic      [3:0]  wb_sel_i,
	output logic             wb_we_i,
	output logic             wb_cyc_i,
	output logic             wb_stb_i
);
	initial begin
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h00000000;
		wb_sel_i = 4'h0;
		wb_we_i  = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
	end

	// One classic cycle; released data is inverted so stale values never look valid
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rdat, output logic berr, output logic tout);
		int n;
		tout = 1'b1;
		berr = 1'b0;
		rdat = 32'h00000000;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hF;
		for (n = 0; n < 16; n++) begin
			@(posedge sys_clk);
			if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
				rdat = wb_dat_o;
				berr = wb_err_o;
				tout = 1'b0;
				break;
			end
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		wb_dat_i <= ~dat;
		@(posedge sys_clk);
	endtask : xfer
endmodule : rcb_host

/* File: rcb_pkg.sv */
// Package: constants, enums and structs for the reversible counter bank
package rcb_pkg;

	// ****************************************
	// Sizes and encodings
	// ****************************************
	localparam int              RCB_SLOTS       = 256;
	localparam int              RCB_IDX_W       = 8;
	localparam int              RCB_CNT_W       = 16;
	localparam logic [15:0]     RCB_BCD_MAX     = 16'h9999;
	localparam logic [15:0]     RCB_BIN_MAX     = 16'hFFFF;
	localparam logic [15:0]     RCB_ZERO        = 16'h0000;
	localparam logic [3:0]      RCB_BCD_DIGIT_MAX = 4'h9;
	localparam logic [3:0]      RCB_BCD_ONE     = 4'h1;
	localparam logic [3:0]      RCB_BCD_NINE    = 4'h9;

	// ****************************************
	// Wishbone register map (byte addresses)
	// ****************************************
	localparam logic [7:0]      RCB_A_CMD       = 8'h00;
	localparam logic [7:0]      RCB_A_SLOT      = 8'h04;
	localparam logic [7:0]      RCB_A_LIMIT     = 8'h08;
	localparam logic [7:0]      RCB_A_RANGE     = 8'h0C;
	localparam logic [7:0]      RCB_A_COUNT     = 8'h10;
	localparam logic [7:0]      RCB_A_STATUS    = 8'h14;
	localparam logic [7:0]      RCB_A_IRQ_ST    = 8'h18;
	localparam logic [7:0]      RCB_A_IRQ_MASK  = 8'h1C;

	// CMD bits
	localparam int              RCB_B_GO        = 0;
	localparam int              RCB_B_RANGE     = 1;
	localparam int              RCB_B_BINARY    = 2;
	localparam int              RCB_B_UP        = 3;
	localparam int              RCB_B_DOWN      = 4;
	localparam int              RCB_B_RESET     = 5;
	localparam int              RCB_B_FIRST_TMR = 6;
	localparam int              RCB_B_LAST_TMR  = 7;

	// Interrupt event bits
	localparam int              RCB_IRQ_W       = 3;
	localparam int              RCB_E_DONE      = 0;
	localparam int              RCB_E_WRAP      = 1;
	localparam int              RCB_E_FAULT     = 2;

	typedef enum logic [1:0] {
		RCB_OP_COUNT_BCD,
		RCB_OP_COUNT_BIN,
		RCB_OP_RANGE_BCD,
		RCB_OP_RANGE_BIN
	} rcb_op_t;

	// One evaluation request
	typedef struct packed {
		rcb_op_t              op;
		logic                 up_count_input;
		logic                 down_count_input;
		logic                 reset_input;
		logic                 first_is_timer;
		logic                 last_is_timer;
		logic [7:0]           slot;
		logic [7:0]           range_first_index;
		logic [7:0]           range_last_index;
		logic [15:0]          preset_limit;
	} rcb_req_t;

	// Stored state of one slot
	typedef struct packed {
		logic [15:0]          present_count;
		logic                 done;
		logic                 up_prev;
		logic                 down_prev;
	} rcb_slot_t;

endpackage : rcb_pkg

/* File: rcb_step.sv */
// Combinational next-state of one reversible counter evaluation
`timescale 1ns/1ps
module rcb_step import rcb_pkg::*; #(
	parameter int W = RCB_CNT_W
) (
	input  wire logic         binary,
	input  wire logic         up_edge,
	input  wire logic         down_edge,
	input  wire logic         reset_input,
	input  wire logic [W-1:0] preset_limit,
	input  wire logic [W-1:0] cur_count,
	input  wire logic         cur_done,
	output logic      [W-1:0] nxt_count,
	output logic              nxt_done,
	output logic              wrapped,
	output logic              bcd_fault
);
	initial begin
		if (W != 16) $error("rcb_step supports only 16-bit counts");
	end

	logic [W-1:0] cnt;
	logic [W-1:0] inc_bcd;
	logic [W-1:0] dec_bcd;
	logic         carry;
	logic         borrow;

	// BCD fault if any digit above nine
	always_comb begin
		bcd_fault = 1'b0;
		for (int d = 0; d < 4; d++) begin
			if (preset_limit[d*4 +: 4] > RCB_BCD_DIGIT_MAX) bcd_fault = 1'b1;
		end
		bcd_fault = bcd_fault & ~binary;
	end

	// Decimal increment and decrement, digit by digit
	always_comb begin
		inc_bcd = RCB_ZERO;
		dec_bcd = RCB_ZERO;
		carry   = 1'b1;
		borrow  = 1'b1;
		for (int d = 0; d < 4; d++) begin
			if (carry && cnt[d*4 +: 4] == RCB_BCD_NINE) begin
				inc_bcd[d*4 +: 4] = 4'h0;
			end else begin
				inc_bcd[d*4 +: 4] = cnt[d*4 +: 4] + {3'h0, carry};
				carry = 1'b0;
			end
			if (borrow && cnt[d*4 +: 4] == 4'h0) begin
				dec_bcd[d*4 +: 4] = RCB_BCD_NINE;
			end else begin
				dec_bcd[d*4 +: 4] = cnt[d*4 +: 4] - {3'h0, borrow};
				borrow = 1'b0;
			end
		end
	end

	always_comb begin
		// A count left above the limit (after a range reset) restarts from the limit
		cnt       = (cur_count > preset_limit) ? preset_limit : cur_count;
		nxt_count = cnt;
		nxt_done  = cur_done;
		wrapped   = 1'b0;
		if (reset_input) begin
			nxt_count = RCB_ZERO;
			nxt_done  = 1'b0;
		end else if (up_edge && down_edge) begin
			nxt_count = cnt;
		end else if (up_edge) begin
			if (cnt == preset_limit) begin
				nxt_count = RCB_ZERO;
				nxt_done  = 1'b1;
				wrapped   = 1'b1;
			end else begin
				nxt_count = binary ? cnt + 16'h0001 : inc_bcd;
				nxt_done  = 1'b0;
			end
		end else if (down_edge) begin
			if (cnt == RCB_ZERO) begin
				nxt_count = preset_limit;
				nxt_done  = 1'b1;
				wrapped   = 1'b1;
			end else begin
				nxt_count = binary ? cnt - 16'h0001 : dec_bcd;
				nxt_done  = 1'b0;
			end
		end
	end

endmodule : rcb_step
